/* design/usb_setup_pkg.sv */
package usb_setup_pkg;
   // register indices on the plain port (byte-free word addresses)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_IN_EP0_CFG = 4'h1;
   localparam logic [3:0] ADDR_OUT_EP0_CFG = 4'h2;
   localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h3;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
   localparam logic [3:0] ADDR_PWR_CTRL = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;
   // control register fields
   localparam int CTRL_MODULE_EN = 0;
   // endpoint config field
   localparam int EPCFG_ENABLE = 7;
   // irq flag fields
   localparam int IRQ_SETUP = 0;
   localparam int IRQ_VBUS_ERR = 1;
   // status fields
   localparam int ST_VBUS_VALID = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_IN_NAK = 2;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] EPCFG_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] PWR_RST = 8'h00;
   // token pid codes
   localparam logic [1:0] TOK_NONE = 2'h0;
   localparam logic [1:0] TOK_SETUP = 2'h1;
   localparam logic [1:0] TOK_IN = 2'h2;
   localparam logic [1:0] TOK_OUT = 2'h3;
   // token decode takes a pid phase then address/crc bits
   localparam int TOKEN_BITS = 16;
endpackage

/* design/usb_token_decoder.sv */
`timescale 1ns/1ps
// follows a token from its pid through address and crc bits; reports the
// decoded kind with a one-cycle strobe once the whole token has passed
module usb_token_decoder (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic tok_start,
   input wire logic [1:0] tok_pid,
   input wire logic tok_bit,
   output logic busy,
   output logic done,
   output logic [1:0] kind
);
   logic [4:0] cnt_r;
   logic busy_r;
   logic done_r;
   logic [1:0] kind_r;
   wire last_bit = busy_r && tok_bit && (cnt_r == 5'(usb_setup_pkg::TOKEN_BITS - 1));

   always_ff @(posedge clk_sys) begin
      if (!rst_b || !enable) begin
         cnt_r <= 5'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         kind_r <= usb_setup_pkg::TOK_NONE;
      end else begin
         done_r <= last_bit;
         if (tok_start && !busy_r) begin
            busy_r <= 1'b1;
            cnt_r <= 5'h00;
            kind_r <= tok_pid;
         end else if (last_bit) begin
            busy_r <= 1'b0;
         end else if (busy_r && tok_bit) begin
            cnt_r <= cnt_r + 5'h01;
         end
      end
   end

   assign busy = busy_r;
   assign done = done_r;
   assign kind = kind_r;
endmodule

/* design/usb_setup_handshake.sv */
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Contract
// - every SETUP token sets the setup flag, which raises the module interrupt when its IRQ_SETUP mask bit is set
// - while the setup flag is set, every IN token gets NAK automatically
// - clearing module enable resets endpoint config, setup flag, pending clear and token decoder; transmit returns to idle
// - with both ep0 enables clear, a setup flag clear is blocked
// - all-zero power control disables regulators and clears vbus error
module usb_setup_handshake (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic tok_start,
   input wire logic [1:0] tok_pid,
   input wire logic tok_bit,
   input wire logic vbus_pin,
   output logic hs_nak,
   output logic hs_data,
   output logic regulator_en,
   output logic irq
);
   typedef enum logic [1:0] {TX_IDLE, TX_NAK, TX_DATA} tx_state_e;

   logic [7:0] ctrl_r;
   logic [7:0] in_cfg_r;
   logic [7:0] out_cfg_r;
   logic [7:0] mask_r;
   logic [7:0] pwr_r;
   logic setup_flag_r;
   logic vbus_err_r;
   logic clear_pend_r;
   logic [7:0] rdata_r;
   logic hs_nak_r;
   logic hs_data_r;
   logic reg_en_r;
   logic irq_r;
   logic vbus_s1_r;
   logic vbus_s2_r;
   logic vbus_seen_r;
   tx_state_e tx_r;
   tx_state_e tx_nxt;

   wire tok_start_s;
   wire tok_bit_s;
   logic st1_r;
   logic st2_r;
   logic bt1_r;
   logic bt2_r;
   logic [1:0] pid1_r;
   logic [1:0] pid2_r;

   always_ff @(posedge clk_sys) begin
      st1_r <= tok_start;
      st2_r <= st1_r;
      bt1_r <= tok_bit;
      bt2_r <= bt1_r;
      pid1_r <= tok_pid;
      pid2_r <= pid1_r;
      vbus_s1_r <= vbus_pin;
      vbus_s2_r <= vbus_s1_r;
   end
   assign tok_start_s = st2_r;
   assign tok_bit_s = bt2_r;

   wire module_en = ctrl_r[usb_setup_pkg::CTRL_MODULE_EN];
   wire tok_busy;
   wire tok_done;
   wire [1:0] tok_kind;

   usb_token_decoder u_dec (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .enable(module_en),
      .tok_start(tok_start_s),
      .tok_pid(pid2_r),
      .tok_bit(tok_bit_s),
      .busy(tok_busy),
      .done(tok_done),
      .kind(tok_kind)
   );

   wire wr_ctrl = reg_wr && (reg_addr == usb_setup_pkg::ADDR_CTRL);
   wire wr_in_cfg = reg_wr && (reg_addr == usb_setup_pkg::ADDR_IN_EP0_CFG);
   wire wr_out_cfg = reg_wr && (reg_addr == usb_setup_pkg::ADDR_OUT_EP0_CFG);
   wire wr_flags = reg_wr && (reg_addr == usb_setup_pkg::ADDR_IRQ_FLAGS);
   wire wr_mask = reg_wr && (reg_addr == usb_setup_pkg::ADDR_IRQ_MASK);
   wire wr_pwr = reg_wr && (reg_addr == usb_setup_pkg::ADDR_PWR_CTRL);

   wire ep0_on = in_cfg_r[usb_setup_pkg::EPCFG_ENABLE] ||
                 out_cfg_r[usb_setup_pkg::EPCFG_ENABLE];
   wire setup_evt = tok_done && (tok_kind == usb_setup_pkg::TOK_SETUP);
   wire in_evt = tok_done && (tok_kind == usb_setup_pkg::TOK_IN);
   wire clr_req = wr_flags && reg_wdata[usb_setup_pkg::IRQ_SETUP] && ep0_on;
   // a clear arriving mid-token is parked until the token is decoded
   wire clr_now = (clr_req || clear_pend_r) && !tok_busy && !tok_done;
   wire pwr_zero = wr_pwr && (reg_wdata == 8'h00);
   wire vbus_err_evt = vbus_seen_r && !vbus_s2_r && (pwr_r != 8'h00);

   wire [7:0] flags = {6'h00, vbus_err_r, setup_flag_r};
   wire [7:0] status = {5'h00, (tx_r == TX_NAK), tok_busy, vbus_s2_r};
   wire irq_src = |(flags & mask_r);
   wire reg_en_src = (pwr_r != 8'h00) && !pwr_zero;

   wire [7:0] rd_mux =
      (reg_addr == usb_setup_pkg::ADDR_CTRL) ? ctrl_r :
      (reg_addr == usb_setup_pkg::ADDR_IN_EP0_CFG) ? in_cfg_r :
      (reg_addr == usb_setup_pkg::ADDR_OUT_EP0_CFG) ? out_cfg_r :
      (reg_addr == usb_setup_pkg::ADDR_IRQ_FLAGS) ? flags :
      (reg_addr == usb_setup_pkg::ADDR_IRQ_MASK) ? mask_r :
      (reg_addr == usb_setup_pkg::ADDR_PWR_CTRL) ? pwr_r :
      (reg_addr == usb_setup_pkg::ADDR_STATUS) ? status : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ctrl_r <= usb_setup_pkg::CTRL_RST;
         pwr_r <= usb_setup_pkg::PWR_RST;
         mask_r <= usb_setup_pkg::MASK_RST;
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= reg_rd ? rd_mux : 8'h00;
         if (wr_ctrl) ctrl_r <= reg_wdata;
         if (wr_pwr) pwr_r <= reg_wdata;
         if (wr_mask) mask_r <= reg_wdata;
      end
   end

   // endpoint, flag and transmit state all fall with the module enable
   always_ff @(posedge clk_sys) begin
      if (!rst_b || !module_en) begin
         in_cfg_r <= usb_setup_pkg::EPCFG_RST;
         out_cfg_r <= usb_setup_pkg::EPCFG_RST;
         setup_flag_r <= 1'b0;
         clear_pend_r <= 1'b0;
         tx_r <= TX_IDLE;
      end else begin
         tx_r <= tx_nxt;
         if (wr_in_cfg) in_cfg_r <= reg_wdata;
         if (wr_out_cfg) out_cfg_r <= reg_wdata;
         if (setup_evt) setup_flag_r <= 1'b1;
         else if (clr_now) setup_flag_r <= 1'b0;
         if (setup_evt || clr_now) clear_pend_r <= 1'b0;
         else if (clr_req) clear_pend_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b || pwr_zero) begin
         vbus_err_r <= 1'b0;
         vbus_seen_r <= 1'b0;
      end else begin
         if (vbus_s2_r) vbus_seen_r <= 1'b1;
         if (vbus_err_evt) vbus_err_r <= 1'b1;
         else if (wr_flags && reg_wdata[usb_setup_pkg::IRQ_VBUS_ERR]) vbus_err_r <= 1'b0;
      end
   end

   // handshakes only answer a decoded IN token
   always_comb begin
      tx_nxt = TX_IDLE;
      case (tx_r)
         TX_IDLE: begin
            if (in_evt && setup_flag_r) tx_nxt = TX_NAK;
            else if (in_evt) tx_nxt = TX_DATA;
         end
         default: tx_nxt = TX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         hs_nak_r <= 1'b0;
         hs_data_r <= 1'b0;
         reg_en_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         hs_nak_r <= (tx_nxt == TX_NAK);
         hs_data_r <= (tx_nxt == TX_DATA);
         reg_en_r <= reg_en_src;
         irq_r <= irq_src;
      end
   end

   assign reg_rdata = rdata_r;
   assign hs_nak = hs_nak_r;
   assign hs_data = hs_data_r;
   assign regulator_en = reg_en_r;
   assign irq = irq_r;

   sequence s_in_while_flag;
      in_evt && setup_flag_r && module_en;
   endsequence

   a_setup_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
      setup_evt && module_en |=> setup_flag_r)
      else $error("setup token did not set flag");
   a_in_nak_auto: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_in_while_flag |=> hs_nak && !hs_data)
      else $error("IN not NAKed while flag set");
   a_enable_resets: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !module_en |=> !setup_flag_r && tx_r == TX_IDLE)
      else $error("module disable did not reset");
   a_gated_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
      setup_flag_r && module_en && !ep0_on && !clear_pend_r && !setup_evt |=> setup_flag_r)
      else $error("flag cleared while ep0 disabled");
   a_pwr_zero_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
      pwr_zero |=> !vbus_err_r ##1 !regulator_en)
      else $error("power zero did not clear error");
   a_no_unsolicited: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (hs_nak || hs_data) |-> $past(in_evt) || !module_en)
      else $error("handshake without IN token");
   a_clear_held: assert property (@(posedge clk_sys) disable iff (!rst_b)
      setup_flag_r && tok_busy && module_en && !setup_evt |=> setup_flag_r)
      else $error("flag cleared during token");
   a_irq_follows: assert property (@(posedge clk_sys) disable iff (!rst_b)
      setup_flag_r && mask_r[usb_setup_pkg::IRQ_SETUP] |=> irq)
      else $error("irq missing for setup flag");

   // a clear that meets a token in flight, a parked clear once the decoder is idle, and an IN with the flag clear
   sequence s_clear_parked;
      clr_req && (tok_busy || tok_done) && !setup_evt && module_en;
   endsequence
   sequence s_pend_free;
      clear_pend_r && !tok_busy && !tok_done && !setup_evt && module_en;
   endsequence
   sequence s_in_flag_clear;
      in_evt && !setup_flag_r && module_en;
   endsequence

   a_clear_parks: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_clear_parked |=> clear_pend_r)
      else $error("clear during token not parked");
   a_parked_applies: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_pend_free |=> !setup_flag_r)
      else $error("parked clear not applied");
   a_blocked_dropped: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wr_flags && reg_wdata[usb_setup_pkg::IRQ_SETUP] && !ep0_on && !clear_pend_r
      |=> !clear_pend_r)
      else $error("blocked clear was kept");
   a_in_data_answer: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_in_flag_clear |=> hs_data && !hs_nak)
      else $error("IN not answered with data");
   a_one_handshake: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !(hs_nak && hs_data))
      else $error("two handshakes at once");
   a_tx_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_b)
      tx_r != TX_IDLE |=> tx_r == TX_IDLE)
      else $error("transmit state did not return to idle");
   a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
      irq == $past(irq_src))
      else $error("irq does not follow flags and mask");
   a_regulator_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
      regulator_en == $past(reg_en_src))
      else $error("regulator enable does not follow power control");
   a_vbus_err_sets: assert property (@(posedge clk_sys) disable iff (!rst_b)
      vbus_err_evt && !pwr_zero |=> vbus_err_r)
      else $error("vbus loss did not set error");
   a_vbus_err_w1c: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wr_flags && reg_wdata[usb_setup_pkg::IRQ_VBUS_ERR] && !vbus_err_evt |=> !vbus_err_r)
      else $error("vbus error not cleared by write one");
   a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_rdata_value: assert property (@(posedge clk_sys) disable iff (!rst_b)
      reg_rd |=> reg_rdata == $past(rd_mux))
      else $error("read data wrong");
   a_done_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
      tok_done |=> !tok_done)
      else $error("token done longer than one cycle");
   a_kind_held: assert property (@(posedge clk_sys) disable iff (!rst_b)
      tok_busy && module_en |=> $stable(tok_kind))
      else $error("token kind changed mid token");
   a_cfg_cleared: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !module_en |=> in_cfg_r == usb_setup_pkg::EPCFG_RST &&
      out_cfg_r == usb_setup_pkg::EPCFG_RST)
      else $error("endpoint config kept while disabled");
   a_mask_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wr_mask |=> mask_r == $past(reg_wdata))
      else $error("mask write lost");
endmodule

/* verification/usb_host_model.sv */
`timescale 1ns/1ps
// host side: sends one token as a start pulse then 16 bit pulses
module usb_host_model (
   input wire logic clk_sys,
   output logic tok_start,
   output logic [1:0] tok_pid,
   output logic tok_bit
);
   initial begin
      tok_start = 1'b0;
      tok_pid = 2'h0;
      tok_bit = 1'b0;
   end
   // gap sets the idle cycles between bit pulses: 1 prompt, larger slow
   task automatic send(input logic [1:0] p, input int gap);
      @(posedge clk_sys);
      tok_pid <= p;
      tok_start <= 1'b1;
      @(posedge clk_sys);
      tok_start <= 1'b0;
      repeat (16) begin
         repeat (gap) @(posedge clk_sys);
         tok_bit <= 1'b1;
         @(posedge clk_sys);
         tok_bit <= 1'b0;
      end
      // kind held past the synchroniser delay, then no longer valid
      repeat (4) @(posedge clk_sys);
      tok_pid <= ~p;
   endtask
endmodule

/* verification/usb_setup_handshake_tb.sv */
`timescale 1ns/1ps
module usb_setup_handshake_tb;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic vbus_pin = 1'b0;
   logic [7:0] reg_rdata;
   logic tok_start, tok_bit, hs_nak, hs_data, regulator_en, irq;
   logic [1:0] tok_pid;
   logic [7:0] d;
   int error_cnt = 0, n_compared = 0, nk = 0, dt = 0, nak_cnt = 0, data_cnt = 0;
   usb_setup_handshake usb_setup_handshake_i (.clk_sys(clk_sys), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tok_start(tok_start), .tok_pid(tok_pid), .tok_bit(tok_bit),
      .vbus_pin(vbus_pin), .hs_nak(hs_nak), .hs_data(hs_data),
      .regulator_en(regulator_en), .irq(irq));
   usb_host_model usb_host_model_i (.clk_sys(clk_sys), .tok_start(tok_start),
      .tok_pid(tok_pid), .tok_bit(tok_bit));
   initial forever #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (hs_nak === 1'b1) nak_cnt++;
      if (hs_data === 1'b1) data_cnt++;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // handshake pulses counted over the token plus the fixed answer delay
   task automatic tok(input logic [1:0] p, input int gap);
      int n0, d0;
      n0 = nak_cnt;
      d0 = data_cnt;
      usb_host_model_i.send(p, gap);
      repeat (8) @(posedge clk_sys);
      nk = nak_cnt - n0;
      dt = data_cnt - d0;
   endtask
   task automatic t_reset();
      rd(usb_setup_pkg::ADDR_CTRL, d); chk(d, usb_setup_pkg::CTRL_RST);
      rd(usb_setup_pkg::ADDR_IN_EP0_CFG, d); chk(d, usb_setup_pkg::EPCFG_RST);
      rd(usb_setup_pkg::ADDR_IRQ_MASK, d); chk(d, usb_setup_pkg::MASK_RST);
      rd(usb_setup_pkg::ADDR_PWR_CTRL, d); chk(d, usb_setup_pkg::PWR_RST);
      rd(4'hF, d); chk(d, 8'h00);
   endtask
   task automatic t_enable();
      wr(usb_setup_pkg::ADDR_CTRL, 8'h01);
      wr(usb_setup_pkg::ADDR_IN_EP0_CFG, 8'h80);
      wr(usb_setup_pkg::ADDR_OUT_EP0_CFG, 8'h80);
      wr(usb_setup_pkg::ADDR_IRQ_MASK, 8'h01);
   endtask
   task automatic t_setup_nak();
      t_enable();
      tok(usb_setup_pkg::TOK_SETUP, 1);
      rd(usb_setup_pkg::ADDR_IRQ_FLAGS, d); chk(d, 8'h01);
      chk({7'h00, irq}, 8'h01);
      repeat (2) begin
         tok(usb_setup_pkg::TOK_IN, 1);
         chk(8'(nk), 8'h01);
         chk(8'(dt), 8'h00);
      end
      wr(usb_setup_pkg::ADDR_IRQ_MASK, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk({7'h00, irq}, 8'h00);
      wr(usb_setup_pkg::ADDR_IRQ_MASK, 8'h01);
   endtask
   task automatic t_gate();
      // gated clear used here on purpose
      wr(usb_setup_pkg::ADDR_IN_EP0_CFG, 8'h00);
      wr(usb_setup_pkg::ADDR_OUT_EP0_CFG, 8'h00);
      wr(usb_setup_pkg::ADDR_IRQ_FLAGS, 8'h01);
      wr(usb_setup_pkg::ADDR_IN_EP0_CFG, 8'h80);
      wr(usb_setup_pkg::ADDR_OUT_EP0_CFG, 8'h80);
      rd(usb_setup_pkg::ADDR_IRQ_FLAGS, d); chk(d, 8'h01);
      tok(usb_setup_pkg::TOK_IN, 1); chk(8'(nk), 8'h01);
      // data assumed loaded before the clear
      wr(usb_setup_pkg::ADDR_IRQ_FLAGS, 8'h01);
      rd(usb_setup_pkg::ADDR_IRQ_FLAGS, d); chk(d, 8'h00);
      chk({7'h00, irq}, 8'h00);
      tok(usb_setup_pkg::TOK_IN, 1);
      chk(8'(dt), 8'h01);
      chk(8'(nk), 8'h00);
   endtask
   task automatic t_park();
      int n0;
      int d0;
      tok(usb_setup_pkg::TOK_SETUP, 1);
      n0 = nak_cnt;
      d0 = data_cnt;
      fork
         usb_host_model_i.send(usb_setup_pkg::TOK_IN, 3);
         begin
            repeat (60) @(posedge clk_sys);
            wr(usb_setup_pkg::ADDR_IRQ_FLAGS, 8'h01);
         end
      join
      repeat (8) @(posedge clk_sys);
      chk(8'(nak_cnt - n0), 8'h01);
      chk(8'(data_cnt - d0), 8'h00);
      rd(usb_setup_pkg::ADDR_IRQ_FLAGS, d); chk(d, 8'h00);
   endtask
   task automatic t_disable();
      tok(usb_setup_pkg::TOK_SETUP, 1);
      wr(usb_setup_pkg::ADDR_CTRL, 8'h00);
      rd(usb_setup_pkg::ADDR_IRQ_FLAGS, d); chk(d, 8'h00);
      rd(usb_setup_pkg::ADDR_IN_EP0_CFG, d); chk(d, 8'h00);
      tok(usb_setup_pkg::TOK_IN, 1); chk(8'(nk + dt), 8'h00);
      chk({7'h00, irq}, 8'h00);
      t_enable();
      tok(usb_setup_pkg::TOK_IN, 1); chk(8'(dt), 8'h01);
   endtask
   task automatic t_power();
      wr(usb_setup_pkg::ADDR_IRQ_MASK, 8'h02);
      wr(usb_setup_pkg::ADDR_PWR_CTRL, 8'h01);
      vbus_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rd(usb_setup_pkg::ADDR_STATUS, d); chk(d & 8'h01, 8'h01);
      chk({7'h00, regulator_en}, 8'h01);
      vbus_pin <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rd(usb_setup_pkg::ADDR_IRQ_FLAGS, d); chk(d, 8'h02);
      chk({7'h00, irq}, 8'h01);
      wr(usb_setup_pkg::ADDR_PWR_CTRL, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk({7'h00, regulator_en}, 8'h00);
      rd(usb_setup_pkg::ADDR_IRQ_FLAGS, d); chk(d, 8'h00);
      wr(usb_setup_pkg::ADDR_PWR_CTRL, 8'h01);
      repeat (2) @(posedge clk_sys);
      chk({7'h00, regulator_en}, 8'h01);
   endtask
   task automatic tally_and_finish();
      $display("compared=%0d errors=%0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset();
      t_setup_nak();
      t_gate();
      t_park();
      t_disable();
      t_power();
      tally_and_finish();
   end
endmodule
